// ### inc/bdg_cfg.svh
// Operation
// - divisor timer runs on the system clock; bit rate follows that clock.
// - async mode, unless high speed and wide both set: three-sample majority.
// - single sample when synchronous, or when high speed and wide both set.
// - async, 8-bit, low speed: rate is clock / (64 * (n + 1)).
// - async with exactly one of high speed or wide: clock / (16 * (n + 1)).
// - synchronous 8-bit: clock / (4 * (n + 1)), high speed ignored.
// - divisor n is high byte concatenated with low byte.
// - divisor held in two separately writable byte registers.
// - a write to either divisor byte clears the divisor timer at once.
// - with wide clear, only the low divisor byte is used.
`ifndef BDG_CFG_SVH
`define BDG_CFG_SVH

`define BDG_ADDR_W       3
`define BDG_OFS_TXCTL    3'h0
`define BDG_OFS_RXCTL    3'h1
`define BDG_OFS_BAUDCTL  3'h2
`define BDG_OFS_DIVHI    3'h3
`define BDG_OFS_DIVLO    3'h4
`define BDG_OFS_STATUS   3'h5

`define BDG_TX_SYNC_BIT  4
`define BDG_TX_HS_BIT    2
`define BDG_RX_EN_BIT    7
`define BDG_BC_WIDE_BIT  3

`define BDG_RST_TXCTL    8'h02
`define BDG_RST_RXCTL    8'h00
`define BDG_RST_BAUDCTL  8'h40
`define BDG_RST_DIV      8'h00

`define BDG_WMASK_TXCTL  8'hfd
`define BDG_WMASK_RXCTL  8'hf8
`define BDG_WMASK_BC     8'hbb

`define BDG_FACTOR_X64   7'd64
`define BDG_FACTOR_X16   7'd16
`define BDG_FACTOR_X4    7'd4

`endif

// ### inc/bdg_pkg.sv
package bdg_pkg;

  // division factor chosen by the mode bits
  typedef enum logic [1:0] {
    rate_x64 = 2'b00,
    rate_x16 = 2'b01,
    rate_x4  = 2'b10
  } bdg_rate_t;

  typedef struct packed {
    logic enable;
    logic sync;
    logic wide;
    logic hs;
  } bdg_cfg_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bdg_bus_t;

  typedef struct packed {
    logic valid;
    logic level;
  } bdg_smp_t;

endpackage

// ### rtl/bdg_timer.sv
module bdg_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic         clr,
  input  wire logic [W-1:0] limit,
  output logic              tick
);

  logic [W-1:0] cnt_r;

  if (W < 2) begin : g_chk
    $error("bdg_timer: W must be at least 2");
  end

  // count 0..limit, so one tick per limit + 1 clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (clr || !run) begin
      cnt_r <= '0;
    end else if (cnt_r >= limit) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // registered wrap pulse; >= guards a limit lowered mid-count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && !clr && (cnt_r >= limit);
    end
  end

endmodule

// ### rtl/bdg_gen.sv
// Our own choices: the register addresses and the plain strobed port.
`include "bdg_cfg.svh"

module bdg_gen #(
  parameter int DIV_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire bdg_pkg::bdg_bus_t bus,
  output logic [7:0]             rdata,
  input  wire logic              rx_in,
  input  wire logic              phase_clr,
  output logic                   base_tick,
  output logic                   bit_tick,
  output bdg_pkg::bdg_smp_t      smp,
  output logic [DIV_W-1:0]       divisor
);

  // the divisor is exactly two byte registers
  if (DIV_W != 16) begin : g_chk
    $error("bdg_gen: DIV_W must be 16");
  end

  // decode of the three mode bits into a division factor
  function automatic bdg_pkg::bdg_rate_t rate_of(
    input bdg_pkg::bdg_cfg_t c
  );
    bdg_pkg::bdg_rate_t r;
    r = bdg_pkg::rate_x4;
    if (c.sync) begin
      r = bdg_pkg::rate_x4;
    end else if (c.hs && c.wide) begin
      r = bdg_pkg::rate_x4;
    end else if (c.hs || c.wide) begin
      r = bdg_pkg::rate_x16;
    end else begin
      r = bdg_pkg::rate_x64;
    end
    return r;
  endfunction

  // factor in base ticks per bit
  function automatic logic [6:0] factor_of(
    input bdg_pkg::bdg_rate_t r
  );
    logic [6:0] f;
    f = `BDG_FACTOR_X4;
    unique case (r)
      bdg_pkg::rate_x64: f = `BDG_FACTOR_X64;
      bdg_pkg::rate_x16: f = `BDG_FACTOR_X16;
      bdg_pkg::rate_x4:  f = `BDG_FACTOR_X4;
      default:           f = `BDG_FACTOR_X4;
    endcase
    return f;
  endfunction

  // three-sample voting applies unless sync or both speed bits set
  function automatic logic vote_on(
    input bdg_pkg::bdg_cfg_t c
  );
    return !c.sync && !(c.hs && c.wide);
  endfunction

  function automatic logic majority(
    input logic a,
    input logic b,
    input logic c
  );
    return (a & b) | (a & c) | (b & c);
  endfunction

  logic [7:0]         txctl_r;
  logic [7:0]         rxctl_r;
  logic [7:0]         baudctl_r;
  logic [7:0]         divhi_r;
  logic [7:0]         divlo_r;
  logic [7:0]         rdata_r;
  logic [7:0]         status;
  logic [7:0]         rd_nxt;
  logic               div_wr;
  logic               wr_tx;
  logic               wr_rx;
  logic               wr_bc;
  logic               wr_hi;
  logic               wr_lo;
  bdg_pkg::bdg_cfg_t  cfg;
  bdg_pkg::bdg_rate_t rate;
  logic [6:0]         factor;
  logic [6:0]         mid;
  logic [6:0]         last;
  logic               vote;
  logic               tmr_clr;
  logic               tmr_tick;
  logic [6:0]         phase_r;
  logic               s0_r;
  logic               s1_r;
  logic               level_r;
  logic               valid_r;
  logic               bit_r;
  logic               base_r;
  logic               seen_r;
  logic [DIV_W-1:0]   div_r;

  // write strobes for each byte register
  assign wr_tx  = bus.wr && (bus.addr == `BDG_OFS_TXCTL);
  assign wr_rx  = bus.wr && (bus.addr == `BDG_OFS_RXCTL);
  assign wr_bc  = bus.wr && (bus.addr == `BDG_OFS_BAUDCTL);
  assign wr_hi  = bus.wr && (bus.addr == `BDG_OFS_DIVHI);
  assign wr_lo  = bus.wr && (bus.addr == `BDG_OFS_DIVLO);
  assign div_wr = wr_hi || wr_lo;

  // transmit control; read-only bit keeps its reset level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txctl_r <= `BDG_RST_TXCTL;
    end else if (wr_tx) begin
      txctl_r <= (txctl_r & ~`BDG_WMASK_TXCTL)
               | (bus.wdata & `BDG_WMASK_TXCTL);
    end
  end

  // receive control; error and ninth bits are not ours to set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxctl_r <= `BDG_RST_RXCTL;
    end else if (wr_rx) begin
      rxctl_r <= (rxctl_r & ~`BDG_WMASK_RXCTL)
               | (bus.wdata & `BDG_WMASK_RXCTL);
    end
  end

  // baud control; unimplemented bit stays zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baudctl_r <= `BDG_RST_BAUDCTL;
    end else if (wr_bc) begin
      baudctl_r <= (baudctl_r & ~`BDG_WMASK_BC)
                 | (bus.wdata & `BDG_WMASK_BC);
    end
  end

  // divisor high byte, written on its own
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divhi_r <= `BDG_RST_DIV;
    end else if (wr_hi) begin
      divhi_r <= bus.wdata;
    end
  end

  // divisor low byte, written on its own
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divlo_r <= `BDG_RST_DIV;
    end else if (wr_lo) begin
      divlo_r <= bus.wdata;
    end
  end

  // mode bits as the generator sees them
  assign cfg.enable = rxctl_r[`BDG_RX_EN_BIT];
  assign cfg.sync   = txctl_r[`BDG_TX_SYNC_BIT];
  assign cfg.hs     = txctl_r[`BDG_TX_HS_BIT];
  assign cfg.wide   = baudctl_r[`BDG_BC_WIDE_BIT];

  assign rate   = rate_of(cfg);
  assign factor = factor_of(rate);
  assign vote   = vote_on(cfg);
  assign mid    = factor >> 1;
  assign last   = factor - 7'd1;

  // effective divisor; high byte ignored in 8-bit mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= '0;
    end else if (cfg.wide) begin
      div_r <= {divhi_r, divlo_r};
    end else begin
      div_r <= {8'h00, divlo_r};
    end
  end

  // a zero divisor is not guarded: the timer then ticks every cycle

  // a divisor write restarts the period; the effective divisor register
  // updates one edge later, so the first count still compares against the old value
  assign tmr_clr = div_wr || phase_clr;

  // timer on the system clock, so rates follow that clock
  bdg_timer #(
    .W (DIV_W)
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .run   (cfg.enable),
    .clr   (tmr_clr),
    .limit (div_r),
    .tick  (tmr_tick)
  );

  // sub-bit phase: factor base ticks make one bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= '0;
    end else if (tmr_clr || !cfg.enable) begin
      phase_r <= '0;
    end else if (tmr_tick) begin
      if (phase_r >= last) begin
        phase_r <= '0;
      end else begin
        phase_r <= phase_r + 7'd1;
      end
    end
  end

  // one-cycle bit strobe at the end of each bit period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_r <= 1'b0;
    end else begin
      bit_r <= tmr_tick && !tmr_clr && (phase_r >= last);
    end
  end

  // base rate strobe, delayed to line up with the bit strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_r <= 1'b0;
    end else begin
      base_r <= tmr_tick && !tmr_clr;
    end
  end

  // first two votes, one base tick before and at mid-bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s0_r <= 1'b0;
      s1_r <= 1'b0;
    end else if (tmr_tick && !tmr_clr) begin
      if (phase_r == mid - 7'd1) begin
        s0_r <= rx_in;
      end
      if (phase_r == mid) begin
        s1_r <= rx_in;
      end
    end
  end

  // decided level: majority of three, or the single mid sample;
  // the x4 rate never votes since mid + 1 would equal the bit end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_r <= 1'b1;
      valid_r <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      if (tmr_tick && !tmr_clr) begin
        if (vote && phase_r == mid + 7'd1) begin
          level_r <= majority(s0_r, s1_r, rx_in);
          valid_r <= 1'b1;
        end else if (!vote && phase_r == mid) begin
          level_r <= rx_in;
          valid_r <= 1'b1;
        end
      end
    end
  end

  // sticky flag: a sample was taken since the status was last read;
  // a new sample in the read cycle wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_r <= 1'b0;
    end else if (valid_r) begin
      seen_r <= 1'b1;
    end else if (bus.rd && bus.addr == `BDG_OFS_STATUS) begin
      seen_r <= 1'b0;
    end
  end

  // block state as software sees it
  assign status = {3'h0, seen_r, level_r, vote, rate};

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_nxt = 8'h00;
    unique case (bus.addr)
      `BDG_OFS_TXCTL:   rd_nxt = txctl_r;
      `BDG_OFS_RXCTL:   rd_nxt = rxctl_r;
      `BDG_OFS_BAUDCTL: rd_nxt = baudctl_r;
      `BDG_OFS_DIVHI:   rd_nxt = divhi_r;
      `BDG_OFS_DIVLO:   rd_nxt = divlo_r;
      `BDG_OFS_STATUS:  rd_nxt = status;
      default:          rd_nxt = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (bus.rd) begin
      rdata_r <= rd_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata     = rdata_r;
  assign base_tick = base_r;
  assign bit_tick  = bit_r;
  assign smp.valid = valid_r;
  assign smp.level = level_r;
  assign divisor   = div_r;

endmodule

// ### dv/bdg_gen_properties.sv
`include "bdg_cfg.svh"
module bdg_chk #(
  parameter int DIV_W = 16
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire bdg_pkg::bdg_bus_t bus,
  input wire logic [7:0]        rdata,
  input wire logic              phase_clr,
  input wire logic              base_tick,
  input wire logic              bit_tick,
  input wire bdg_pkg::bdg_smp_t smp,
  input wire logic [DIV_W-1:0]  divisor
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DIV_W-1:0] gap_r;
  logic [DIV_W-1:0] div_q;
  logic             seen_r;
  logic             wide_r;
  // clocks since last base tick; any restart voids the next compare,
  // and so does a divisor change from the wide select alone, which
  // reaches the timer without clearing it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_r <= '0;
      div_q <= '0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= base_tick ? '0 : gap_r + 1'b1;
      div_q <= divisor;
      seen_r <= (base_tick | seen_r) & ~bus.wr & ~phase_clr
              & (divisor == div_q);
    end
  end
  // shadow of the wide select, taken from bus writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wide_r <= 1'b0;
    end else if (bus.wr && bus.addr == `BDG_OFS_BAUDCTL) begin
      wide_r <= bus.wdata[`BDG_BC_WIDE_BIT];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_lo_wr;
    bus.wr && bus.addr == `BDG_OFS_DIVLO;
  endsequence
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_divlo_load: assert property (
    s_lo_wr |-> ##2 divisor[7:0] == $past(bus.wdata, 2))
    else $error("low divisor byte not in effective divisor");
  a_base_period: assert property (
    base_tick && seen_r && divisor != 0 |-> gap_r == divisor)
    else $error("base tick spacing differs from divisor plus one");
  a_wr_restart: assert property (s_lo_wr |-> ##2 !base_tick)
    else $error("base tick too soon after divisor write");
  a_narrow_div: assert property (
    !wide_r && !$past(wide_r) |-> divisor[15:8] == 8'h00)
    else $error("high byte used with narrow divisor");
  a_unmapped_zero: assert property (
    bus.rd && bus.addr > `BDG_OFS_STATUS |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_bit_pulse: assert property (bit_tick && divisor != 0 |=> !bit_tick)
    else $error("bit tick longer than one cycle");
  a_smp_pulse: assert property (smp.valid && divisor != 0 |=> !smp.valid)
    else $error("sample valid longer than one cycle");
endmodule
bind bdg_gen bdg_chk #(.DIV_W(DIV_W)) bdg_chk_inst (.clk(clk), .rst(rst),
  .bus(bus), .rdata(rdata), .phase_clr(phase_clr), .base_tick(base_tick),
  .bit_tick(bit_tick), .smp(smp), .divisor(divisor));

// ### dv/baud_rate_generator_tb_top.sv
`include "bdg_cfg.svh"
module baud_rate_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  tx, bc, hi, lo, st;
    logic [15:0] n, per;
  } bdg_row_t;
  logic              clk, rst, rx_in, phase_clr, base_tick, bit_tick;
  bdg_pkg::bdg_bus_t bus;
  bdg_pkg::bdg_smp_t smp;
  logic [7:0]        rdata, d;
  logic [15:0]       divisor, c;
  int                n_fail, checked, cyc;
  // mode bits, divisor, expected status, n and bit period in clocks;
  // status is seen, level, vote, rate code
  bdg_row_t rows [6] = '{
    '{8'h00, 8'h00, 8'h00, 8'h01, 8'h14, 16'h0001, 16'h0080},
    '{8'h04, 8'h00, 8'h00, 8'h02, 8'h1d, 16'h0002, 16'h0030},
    '{8'h00, 8'h08, 8'h00, 8'h03, 8'h15, 16'h0003, 16'h0040},
    '{8'h04, 8'h08, 8'h01, 8'h00, 8'h1a, 16'h0100, 16'h0404},
    '{8'h14, 8'h00, 8'h01, 8'h04, 8'h12, 16'h0004, 16'h0014},
    '{8'h10, 8'h08, 8'h00, 8'h05, 8'h1a, 16'h0005, 16'h0018}};
  logic [7:0] rv [5] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00};

  bdg_gen bdg_gen_inst (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .rx_in(rx_in), .phase_clr(phase_clr), .base_tick(base_tick),
    .bit_tick(bit_tick), .smp(smp), .divisor(divisor));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  // clocks between two ticks; bounded so a dead timer cannot hang
  task automatic span(input logic sel, output logic [15:0] n);
    int k;
    n = 16'h0000;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while ((sel ? bit_tick : base_tick) !== 1'b1 && k < 3000);
    do begin
      @(negedge clk);
      n++;
    end while ((sel ? bit_tick : base_tick) !== 1'b1 && n < 16'h0bb8);
  endtask

  task automatic check_reset();
    for (int i = 0; i < 5; i++) begin
      rd(i[2:0], d);
      chk({8'h00, d}, {8'h00, rv[i]});
    end
    chk({15'h0, smp.level}, 16'h0001);
    chk(divisor, 16'h0000);
    $display("reset values done");
  endtask

  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard, well above the longest row
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    bus = '0;
    rx_in = 1'b1;
    phase_clr = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    check_reset();
    for (int i = 0; i < 6; i++) begin
      // bytes before the wide select; the live divisor still reads 0 in row 0, between its high and low byte writes
      wr(`BDG_OFS_TXCTL, rows[i].tx);
      wr(`BDG_OFS_DIVHI, rows[i].hi);
      wr(`BDG_OFS_DIVLO, rows[i].lo);
      wr(`BDG_OFS_BAUDCTL, rows[i].bc);
      wr(`BDG_OFS_RXCTL, 8'h80);
      rx_in <= i[0];
      phase_clr <= 1'b1;
      @(posedge clk);
      phase_clr <= 1'b0;
      span(1'b0, c);
      chk(c, rows[i].n + 16'h0001);
      span(1'b1, c);
      chk(c, rows[i].per);
      chk(divisor, rows[i].n);
      chk({15'h0, smp.level}, {15'h0, i[0]});
      rd(`BDG_OFS_STATUS, d);
      chk({8'h00, d}, {8'h00, rows[i].st});
      $display("mode row %0d done", i);
    end
    // read-only receive control bits keep their value, byte reads back whole
    wr(`BDG_OFS_DIVHI, 8'ha5);
    rd(`BDG_OFS_DIVHI, d);
    chk({8'h00, d}, 16'h00a5);
    wr(`BDG_OFS_RXCTL, 8'hff);
    rd(`BDG_OFS_RXCTL, d);
    chk({8'h00, d}, 16'h00f8);
    wr(3'h6, 8'hff);
    rd(3'h6, d);
    chk({8'h00, d}, 16'h0000);
    $display("register access done");
    // second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check_reset();
    final_report();
  end
endmodule
